// file: common/ee_cfg.svh
// Constants for the serial EEPROM link: codes, sizes and timing counts
`ifndef EE_CFG_SVH
`define EE_CFG_SVH

`define EE_DEV_CODE 4'hA
`define EE_ADDR_W 10
`define EE_MEM_WORDS 1024
`define EE_PAGE_BYTES 16
`define EE_PAGE_BITS 4
`define EE_BYTE_BITS 8
`define EE_ACK_BIT 4'h8

// Device side runs on the link clock
`define EE_DEV_CLK_NS 12
`define EE_WRITE_TIME_NS 3000
`define EE_WRITE_CYC ((`EE_WRITE_TIME_NS + `EE_DEV_CLK_NS - 1) / `EE_DEV_CLK_NS)

// Controller side divides its own clock down to SCL
`define EE_SYS_HZ 40000000
`define EE_SCL_HZ 400000
`define EE_SCL_QTR_CYC (`EE_SYS_HZ / (4 * `EE_SCL_HZ))

`endif

// file: common/ee_pkg.sv
// Types shared by both ends of the serial EEPROM link
package ee_pkg;

  typedef enum logic [2:0] {
    EE_D_IDLE = 3'h0,
    EE_D_CTRL = 3'h1,
    EE_D_ADDR = 3'h3,
    EE_D_WDATA = 3'h2,
    EE_D_RDATA = 3'h6
  } ee_dev_state_t;

  typedef enum logic [1:0] {
    EE_H_IDLE = 2'h0,
    EE_H_START = 2'h1,
    EE_H_BIT = 2'h3,
    EE_H_STOP = 2'h2
  } ee_host_state_t;

  typedef enum logic [1:0] {
    EE_OP_WRITE = 2'h0,
    EE_OP_READ_RAND = 2'h1,
    EE_OP_READ_CUR = 2'h3,
    EE_OP_POLL = 2'h2
  } ee_op_t;

  typedef struct packed {
    ee_dev_state_t st;
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    logic wp1;
    logic wp2;
    logic rst1;
    logic rst2;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic ackb;
    logic rw;
    logic [9:0] ptr;
    logic [15:0][7:0] pbuf;
    logic [15:0] pval;
    logic busy;
    logic [4:0] widx;
    logic [15:0] cnt;
    logic oe;
  } ee_dev_state_rec_t;

  typedef struct packed {
    ee_host_state_t st;
    logic [7:0] div;
    logic [1:0] ph;
    logic scl;
    logic oe;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [1:0] stage;
    logic [7:0] cnt;
    ee_op_t op;
    logic [9:0] addr;
    logic last;
    logic nack;
    logic cmd_rdy;
    logic wrdy;
    logic rvalid;
    logic [7:0] rdata;
    logic done;
    logic sda1;
    logic sda2;
  } ee_host_state_rec_t;

endpackage

// file: common/ee_if.sv
// Two-wire link between controller and EEPROM, with open-drain SDA
`timescale 1ns/1ps
interface ee_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic sda;

  // Wired-AND of both drivers with the pull-up
  assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));

  modport dev (
    input scl,
    input sda,
    output d_sda_o,
    output d_sda_oe
  );

  modport host (
    output scl,
    input sda,
    output m_sda_o,
    output m_sda_oe
  );
endinterface

// file: rtl/ee_dev.sv
// EEPROM target end: command decode, page buffer, write cycle and reads
// What this block does
// - Extra page bytes wrap and overwrite buffered ones
// - Stop after write starts timed write cycle
// - Page write never crosses into next page
// - Controller sends every page-write byte it is given; this block wraps them inside one page
// - Protect strap high at the stop blocks the array write for that page
// - No control-byte acknowledge while write cycle runs
// - Controller polls with write control byte
// - Direction bit one selects read behaviour
// - Pointer holds last accessed location plus one
// - Read control byte acked, then byte shifted out
// - Word address loads pointer before repeated start
// - Controller acknowledge fetches next sequential byte
// - Pointer advances by one per byte
// - Acknowledge only the fixed device-type code
// - Two block-select bits form upper address
// - Page write increments only low four bits
// - Page buffer holds sixteen bytes
`timescale 1ns/1ps
`include "ee_cfg.svh"

module ee_dev
  import ee_pkg::*;
#(
  parameter int WRITE_CYC = `EE_WRITE_CYC
) (
  input wire logic link_clk,
  input wire logic reset,
  ee_if.dev bus,
  input wire logic wp,
  output logic busy
);

  ee_dev_state_rec_t r_reg;
  ee_dev_state_rec_t r_next;

  // Array lives outside the state record; it is never reset
  logic [7:0] mem [0:`EE_MEM_WORDS-1];
  logic mem_we;
  logic [9:0] mem_wa;
  logic [7:0] mem_wd;

  logic rise;
  logic fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] rx_byte;

  ////////////////////////////////////////////////////////////////////////
  // Line events, seen only on the second and third stages
  assign rise = r_reg.scl2 && !r_reg.scl3;
  assign fall = !r_reg.scl2 && r_reg.scl3;
  assign start_cond = r_reg.scl2 && r_reg.scl3 && r_reg.sda3 && !r_reg.sda2;
  assign stop_cond = r_reg.scl2 && r_reg.scl3 && !r_reg.sda3 && r_reg.sda2;
  assign rx_byte = {r_reg.sh[6:0], r_reg.sda2};

  ////////////////////////////////////////////////////////////////////////
  // Control byte carries this device's type code
  function automatic logic code_hit(input logic [7:0] ctrl);
    return ctrl[7:4] == `EE_DEV_CODE;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    r_next = r_reg;
    mem_we = 1'b0;
    mem_wa = {r_reg.ptr[9:4], r_reg.widx[3:0]};
    mem_wd = r_reg.pbuf[r_reg.widx[3:0]];

    // Two-stage synchronisers for the pins
    r_next.scl1 = bus.scl;
    r_next.scl2 = r_reg.scl1;
    r_next.scl3 = r_reg.scl2;
    r_next.sda1 = bus.sda;
    r_next.sda2 = r_reg.sda1;
    r_next.sda3 = r_reg.sda2;
    r_next.wp1 = wp;
    r_next.wp2 = r_reg.wp1;

    // Commit runs alongside the timer; pointer is frozen because nothing is acked
    if (r_reg.busy) begin
      if (!r_reg.widx[4]) begin
        mem_we = r_reg.pval[r_reg.widx[3:0]];
        r_next.widx = r_reg.widx + 5'h01;
      end
      if (r_reg.cnt == 16'h0000) begin
        r_next.busy = 1'b0;
      end else begin
        r_next.cnt = r_reg.cnt - 16'h0001;
      end
    end

    if (start_cond) begin
      // Repeated start drops an unfinished page write
      r_next.st = EE_D_CTRL;
      r_next.bitc = 4'h0;
      r_next.oe = 1'b0;
      r_next.pval = 16'h0000;
    end else if (stop_cond) begin
      r_next.st = EE_D_IDLE;
      r_next.oe = 1'b0;
      if (r_reg.st == EE_D_WDATA && |r_reg.pval && !r_reg.wp2 && !r_reg.busy) begin
        r_next.busy = 1'b1;
        r_next.widx = 5'h00;
        r_next.cnt = 16'(WRITE_CYC - 1);
      end
    end else if (rise && r_reg.st != EE_D_IDLE) begin
      if (r_reg.bitc != `EE_ACK_BIT) begin
        r_next.bitc = r_reg.bitc + 4'h1;
        if (r_reg.st == EE_D_RDATA) begin
          r_next.sh = {r_reg.sh[6:0], 1'b0};
        end else begin
          r_next.sh = rx_byte;
        end
        // Eighth bit in: decide the acknowledge and act on the byte
        if (r_reg.bitc == 4'h7 && r_reg.st != EE_D_RDATA) begin
          unique case (r_reg.st)
            EE_D_CTRL: begin
              r_next.ackb = code_hit(rx_byte) && !r_reg.busy;
              r_next.rw = rx_byte[0];
              if (code_hit(rx_byte) && !r_reg.busy) begin
                r_next.ptr[9:8] = rx_byte[2:1];
              end
            end
            EE_D_ADDR: begin
              r_next.ackb = 1'b1;
              r_next.ptr[7:0] = rx_byte;
            end
            EE_D_WDATA: begin
              // Acked even when protected; the stop decides
              r_next.ackb = 1'b1;
              r_next.pbuf[r_reg.ptr[3:0]] = rx_byte;
              r_next.pval[r_reg.ptr[3:0]] = 1'b1;
              r_next.ptr[3:0] = r_reg.ptr[3:0] + 4'h1;
            end
            default: begin
              r_next.ackb = 1'b0;
            end
          endcase
        end
      end else begin
        // Acknowledge clock
        r_next.bitc = 4'h0;
        unique case (r_reg.st)
          EE_D_CTRL: begin
            if (!r_reg.ackb) begin
              r_next.st = EE_D_IDLE;
            end else if (r_reg.rw) begin
              r_next.st = EE_D_RDATA;
              r_next.sh = mem[r_reg.ptr];
              r_next.ptr = r_reg.ptr + 10'h001;
            end else begin
              r_next.st = EE_D_ADDR;
            end
          end
          EE_D_ADDR: begin
            r_next.st = EE_D_WDATA;
            r_next.pval = 16'h0000;
          end
          EE_D_WDATA: begin
            r_next.st = EE_D_WDATA;
          end
          EE_D_RDATA: begin
            if (r_reg.sda2) begin
              // No acknowledge: let go and wait for stop
              r_next.st = EE_D_IDLE;
            end else begin
              r_next.sh = mem[r_reg.ptr];
              r_next.ptr = r_reg.ptr + 10'h001;
            end
          end
          default: begin
            r_next.st = EE_D_IDLE;
          end
        endcase
      end
    end else if (fall) begin
      // SDA only changes while SCL is low
      if (r_reg.st == EE_D_RDATA) begin
        r_next.oe = (r_reg.bitc != `EE_ACK_BIT) && !r_reg.sh[7];
      end else if (r_reg.st != EE_D_IDLE) begin
        r_next.oe = (r_reg.bitc == `EE_ACK_BIT) && r_reg.ackb;
      end else begin
        r_next.oe = 1'b0;
      end
    end

    // Reset comes from the controller's clock, so it is used after two stages
    if (r_reg.rst2) begin
      r_next = '0;
      r_next.st = EE_D_IDLE;
      r_next.scl1 = 1'b1;
      r_next.scl2 = 1'b1;
      r_next.scl3 = 1'b1;
      r_next.sda1 = 1'b1;
      r_next.sda2 = 1'b1;
      r_next.sda3 = 1'b1;
      mem_we = 1'b0;
    end
    r_next.rst1 = reset;
    r_next.rst2 = r_reg.rst1;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge link_clk) begin
    r_reg <= r_next;
  end

  // Array write port, one byte per cycle during commit
  always_ff @(posedge link_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the record; SDA data pin tied low
  assign bus.d_sda_oe = r_reg.oe;
  assign bus.d_sda_o = 1'b0;
  assign busy = r_reg.busy;

endmodule

// file: rtl/ee_host.sv
// Controller end: SCL divider, start/stop, byte shifting and command sequencing
`timescale 1ns/1ps
`include "ee_cfg.svh"

module ee_host
  import ee_pkg::*;
#(
  parameter int QTR_CYC = `EE_SCL_QTR_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  ee_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire ee_op_t cmd_op,
  input wire logic [9:0] cmd_addr,
  input wire logic [7:0] cmd_len,
  input wire logic wdata_valid,
  input wire logic [7:0] wdata,
  output logic wdata_ready,
  output logic rdata_valid,
  output logic [7:0] rdata,
  output logic done,
  output logic nack
);

  ee_host_state_rec_t r_reg;
  ee_host_state_rec_t r_next;
  logic tick;
  logic rx;

  assign tick = r_reg.div == 8'(QTR_CYC - 1);
  // Receiving only in the data stage of a read
  assign rx = (r_reg.stage == 2'h3) && (r_reg.op != EE_OP_WRITE);

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic; each bit is four SCL quarters
  always_comb begin
    r_next = r_reg;
    r_next.sda1 = bus.sda;
    r_next.sda2 = r_reg.sda1;
    r_next.rvalid = 1'b0;
    r_next.done = 1'b0;
    r_next.div = tick ? 8'h00 : r_reg.div + 8'h01;

    unique case (r_reg.st)
      EE_H_IDLE: begin
        r_next.cmd_rdy = 1'b1;
        if (r_reg.cmd_rdy && cmd_valid) begin
          r_next.cmd_rdy = 1'b0;
          r_next.op = cmd_op;
          r_next.addr = cmd_addr;
          r_next.cnt = cmd_len;
          r_next.nack = 1'b0;
          r_next.ph = 2'h0;
          r_next.stage = (cmd_op == EE_OP_READ_CUR) ? 2'h2 : 2'h0;
          r_next.st = EE_H_START;
        end
      end
      EE_H_START: begin
        if (tick) begin
          r_next.ph = r_reg.ph + 2'h1;
          unique case (r_reg.ph)
            2'h0: r_next.oe = 1'b0;
            2'h1: r_next.scl = 1'b1;
            2'h2: r_next.oe = 1'b1;
            2'h3: begin
              r_next.scl = 1'b0;
              // Direction bit is one only for the read control byte
              r_next.sh = {`EE_DEV_CODE, 1'b0, r_reg.addr[9:8], r_reg.stage == 2'h2};
              r_next.bitc = 4'h0;
              r_next.st = EE_H_BIT;
            end
          endcase
        end
      end
      EE_H_BIT: begin
        if (r_reg.wrdy) begin
          // SCL held low until the next write byte arrives
          if (wdata_valid) begin
            r_next.wrdy = 1'b0;
            r_next.sh = wdata;
            r_next.bitc = 4'h0;
            r_next.stage = 2'h3;
            r_next.ph = 2'h0;
          end
        end else if (tick) begin
          r_next.ph = r_reg.ph + 2'h1;
          unique case (r_reg.ph)
            2'h0: begin
              r_next.scl = 1'b0;
              if (r_reg.bitc != `EE_ACK_BIT) begin
                r_next.oe = !rx && !r_reg.sh[7];
              end else begin
                r_next.oe = rx && !r_reg.last;
              end
            end
            2'h1: r_next.scl = 1'b1;
            2'h2: begin
              if (r_reg.bitc != `EE_ACK_BIT && rx) begin
                r_next.sh = {r_reg.sh[6:0], r_reg.sda2};
              end
              if (r_reg.bitc == `EE_ACK_BIT && !rx) begin
                r_next.nack = r_reg.sda2;
              end
            end
            2'h3: begin
              r_next.scl = 1'b0;
              if (r_reg.bitc != `EE_ACK_BIT) begin
                r_next.bitc = r_reg.bitc + 4'h1;
                if (!rx) begin
                  r_next.sh = {r_reg.sh[6:0], 1'b0};
                end
              end else if (!rx && r_reg.nack) begin
                r_next.st = EE_H_STOP;
              end else begin
                unique case (r_reg.stage)
                  2'h0: begin
                    if (r_reg.op == EE_OP_POLL) begin
                      r_next.st = EE_H_STOP;
                    end else begin
                      r_next.sh = r_reg.addr[7:0];
                      r_next.bitc = 4'h0;
                      r_next.stage = 2'h1;
                    end
                  end
                  2'h1: begin
                    if (r_reg.op == EE_OP_WRITE) begin
                      r_next.wrdy = 1'b1;
                      r_next.ph = 2'h3;
                    end else begin
                      r_next.stage = 2'h2;
                      r_next.st = EE_H_START;
                    end
                  end
                  2'h2: begin
                    r_next.stage = 2'h3;
                    r_next.bitc = 4'h0;
                    r_next.last = r_reg.cnt == 8'h01;
                  end
                  2'h3: begin
                    if (rx) begin
                      r_next.rvalid = 1'b1;
                      r_next.rdata = r_reg.sh;
                      r_next.bitc = 4'h0;
                      r_next.last = r_reg.cnt == 8'h02;
                    end else begin
                      r_next.wrdy = 1'b1;
                      r_next.ph = 2'h3;
                    end
                    r_next.cnt = r_reg.cnt - 8'h01;
                    if (r_reg.cnt == 8'h01) begin
                      r_next.wrdy = 1'b0;
                      r_next.ph = 2'h0;
                      r_next.st = EE_H_STOP;
                    end
                  end
                endcase
              end
            end
          endcase
        end
      end
      EE_H_STOP: begin
        if (tick) begin
          r_next.ph = r_reg.ph + 2'h1;
          unique case (r_reg.ph)
            2'h0: begin
              r_next.scl = 1'b0;
              r_next.oe = 1'b1;
            end
            2'h1: r_next.scl = 1'b1;
            2'h2: r_next.oe = 1'b0;
            2'h3: begin
              r_next.done = 1'b1;
              r_next.st = EE_H_IDLE;
            end
          endcase
        end
      end
    endcase

    if (reset) begin
      r_next = '0;
      r_next.st = EE_H_IDLE;
      r_next.op = EE_OP_WRITE;
      r_next.scl = 1'b1;
      r_next.sda1 = 1'b1;
      r_next.sda2 = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys) begin
    r_reg <= r_next;
  end

  assign bus.scl = r_reg.scl;
  assign bus.m_sda_oe = r_reg.oe;
  assign bus.m_sda_o = 1'b0;
  assign cmd_ready = r_reg.cmd_rdy;
  assign wdata_ready = r_reg.wrdy;
  assign rdata_valid = r_reg.rvalid;
  assign rdata = r_reg.rdata;
  assign done = r_reg.done;
  assign nack = r_reg.nack;

endmodule

// file: tb/ee_link_monitor.sv
// Link checker: open-drain discipline, bit timing and framing on the two-wire bus
`timescale 1ns/1ps
module ee_link_monitor (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////////
  // Framing conditions seen on the wire
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $rose(sda);
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  // Open drain: nobody ever drives the line high
  property p_dev_od;
    d_sda_oe |-> !d_sda_o;
  endproperty
  a_dev_od: assert property (p_dev_od) else $error("device drives sda high");
  property p_host_od;
    m_sda_oe |-> !m_sda_o;
  endproperty
  a_host_od: assert property (p_host_od) else $error("host drives sda high");
  // Device only moves its data while the clock is low
  property p_dev_moves_low;
    $changed(d_sda_oe) |-> !scl;
  endproperty
  a_dev_moves_low: assert property (p_dev_moves_low) else $error("device moved sda with scl high");
  // Data held through the first part of every high phase
  property p_bit_stable;
    $rose(scl) |-> $stable(sda) [*8];
  endproperty
  a_bit_stable: assert property (p_bit_stable) else $error("sda moved early in high phase");
  // Repeated start only once the device has let go
  property p_start_no_dev;
    s_start |-> !d_sda_oe;
  endproperty
  a_start_no_dev: assert property (p_start_no_dev) else $error("device drives during start");
  // Stop leaves a released, idle bus
  property p_stop_idle;
    s_stop |-> (!d_sda_oe && scl) [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
  // Device drive never outlasts an ack plus one byte
  property p_dev_release;
    $rose(d_sda_oe) |-> ##[1:420] !d_sda_oe;
  endproperty
  a_dev_release: assert property (p_dev_release) else $error("device holds sda too long");
  // Clocking follows every start
  property p_start_then_clock;
    s_start |-> ##[1:40] !scl;
  endproperty
  a_start_then_clock: assert property (p_start_then_clock) else $error("no clock after start");
  property p_reset_idle;
    $fell(reset) |-> (scl && sda);
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("bus not idle after reset");
  c_stop: cover property (s_stop);
endmodule

// file: tb/tb_top.sv
// Bench for both link ends: page writes, polling, protection and reads
`timescale 1ns/1ps
module tb_top
  import ee_pkg::*;
;
  localparam int QTR = 10;
  localparam int WCYC = 2000;
  logic clk_sys, link_clk, reset, wp, busy;
  logic cmd_valid, cmd_ready, wdata_valid, wdata_ready, rdata_valid, done, nack;
  ee_op_t cmd_op;
  logic [9:0] cmd_addr;
  logic [7:0] cmd_len, wdata, rdata;
  logic [7:0] exp_mem [0:1023];
  logic [7:0] wq[$];
  logic [7:0] rq[$];
  int err_count;
  int compares;

  ee_if i_ee_if ();
  ee_host #(.QTR_CYC(QTR)) i_ee_host (.clk_sys(clk_sys), .reset(reset), .bus(i_ee_if), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wdata_valid(wdata_valid),
    .wdata(wdata), .wdata_ready(wdata_ready), .rdata_valid(rdata_valid), .rdata(rdata), .done(done), .nack(nack));
  ee_dev #(.WRITE_CYC(WCYC)) i_ee_dev (.link_clk(link_clk), .reset(reset), .bus(i_ee_if), .wp(wp), .busy(busy));
  ee_link_monitor i_ee_link_monitor (.clk_sys(clk_sys), .reset(reset), .scl(i_ee_if.scl), .sda(i_ee_if.sda),
    .m_sda_o(i_ee_if.m_sda_o), .m_sda_oe(i_ee_if.m_sda_oe), .d_sda_o(i_ee_if.d_sda_o),
    .d_sda_oe(i_ee_if.d_sda_oe));

  ////////////////////////////////////////////////////////////////////////////////
  // Clocks: link clock offset so the two never line up
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #6 link_clk = ~link_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write feeder and read collector
  always @(negedge clk_sys) begin
    wdata_valid <= (wdata_ready === 1'b1) && (wq.size() > 0);
    if (wq.size() > 0) begin
      wdata <= wq[0];
    end
  end
  always @(posedge clk_sys) begin
    if (wdata_valid && wdata_ready === 1'b1) begin
      void'(wq.pop_front());
    end
    if (rdata_valid === 1'b1) begin
      rq.push_back(rdata);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One command, held until taken, then wait for its done pulse
  task automatic run_cmd(input ee_op_t op, input logic [9:0] addr, input logic [7:0] len);
    int n;
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = addr;
    cmd_len = len;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (cmd_ready !== 1'b1 && n < 1000);
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (done !== 1'b1 && n < 20000);
    @(negedge clk_sys);
    check("command done", {7'h00, done === 1'b0 && n < 20000}, 8'h01);
  endtask

  // Model follows in-page wrap of the low four address bits
  task automatic write_bytes(input logic [9:0] addr, input int n, input logic [7:0] base);
    logic [9:0] a;
    a = addr;
    for (int i = 0; i < n; i++) begin
      wq.push_back(base + 8'(i));
      if (wp == 1'b0) begin
        exp_mem[a] = base + 8'(i);
      end
      a = {a[9:4], a[3:0] + 4'h1};
    end
    run_cmd(EE_OP_WRITE, addr, 8'(n));
    check("write nack", {7'h00, nack}, 8'h00);
  endtask

  task automatic read_cmp(input ee_op_t op, input logic [9:0] addr, input int n);
    rq.delete();
    run_cmd(op, addr, 8'(n));
    check("read nack", {7'h00, nack}, 8'h00);
    check("read count", 8'(rq.size()), 8'(n));
    for (int i = 0; i < n; i++) begin
      check("read byte", (i < rq.size()) ? rq[i] : 8'hXX, exp_mem[10'(addr + i)]);
    end
  endtask

  // Poll with write control bytes until the device answers again
  task automatic poll_wait(input logic expect_busy);
    int k;
    run_cmd(EE_OP_POLL, 10'h000, 8'h00);
    check("first poll nack", {7'h00, nack}, {7'h00, expect_busy});
    k = 0;
    while (nack === 1'b1 && k < 20) begin
      run_cmd(EE_OP_POLL, 10'h000, 8'h00);
      k++;
    end
    check("poll acked", {7'h00, nack}, 8'h00);
    check("busy after poll", {7'h00, busy}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'b1;
    wp = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = EE_OP_WRITE;
    cmd_addr = 10'h000;
    cmd_len = 8'h00;
    wdata_valid = 1'b0;
    wdata = 8'h00;
    err_count = 0;
    compares = 0;
    repeat (20) @(negedge clk_sys);
    reset = 1'b0;
    repeat (10) @(negedge clk_sys);
    // Twenty bytes from mid-page: four overwrite the earliest ones
    write_bytes(10'h1F8, 20, 8'h40);
    repeat (4) @(negedge clk_sys);
    check("busy after stop", {7'h00, busy}, 8'h01);
    poll_wait(1'b1);
    read_cmp(EE_OP_READ_RAND, 10'h1F0, 15);
    read_cmp(EE_OP_READ_CUR, 10'h1FF, 1);
    // Top location then zero, read across the array end
    // Single bytes stay inside their page
    write_bytes(10'h3FF, 1, 8'hA5);
    poll_wait(1'b1);
    write_bytes(10'h000, 1, 8'h5A);
    poll_wait(1'b1);
    read_cmp(EE_OP_READ_RAND, 10'h3FF, 2);
    // Protected: acked, no write cycle, array unchanged
    wp = 1'b1;
    repeat (4) @(negedge clk_sys);
    write_bytes(10'h1F0, 2, 8'hEE);
    repeat (20) @(negedge clk_sys);
    check("busy under protect", {7'h00, busy}, 8'h00);
    poll_wait(1'b0);
    read_cmp(EE_OP_READ_RAND, 10'h1F0, 2);
    wp = 1'b0;
    print_verdict();
  end

  // Watchdog sized well past the expected run
  initial begin
    repeat (90000) @(posedge clk_sys);
    err_count++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    print_verdict();
  end
endmodule
